// ### hw/gpio_pkg.sv
package gpio_pkg;

    // ------------
    // geometry and bus
    // ------------
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 8;
    localparam int NUM_PORTS = 4;
    localparam int PINS      = 8;

    // ------------
    // register offsets
    // ------------
    localparam logic [15:0] DATA_OFS [NUM_PORTS] = '{16'h0080, 16'h0088, 16'h0090, 16'h0098};
    localparam logic [15:0] DIR_OFS  [NUM_PORTS] = '{16'h0089, 16'h0091, 16'h0099, 16'h00a1};
    localparam logic [15:0] PU_OFS   [NUM_PORTS] = '{16'h2f00, 16'h2f01, 16'h2f02, 16'h2f03};
    localparam logic [15:0] OD_OFS   [NUM_PORTS] = '{16'h2f0c, 16'h2f0d, 16'h2f0e, 16'h2f0f};
    localparam logic [15:0] DB_OFS   [NUM_PORTS] = '{16'h2f18, 16'h2f19, 16'h2f1a, 16'h2f1b};
    localparam logic [15:0] PCI_OFS        = 16'h00ae;
    localparam logic [15:0] ANA_LOW_OFS    = 16'h2f50;
    localparam logic [15:0] ANA_HIGH_OFS   = 16'h2f51;
    localparam logic [15:0] IRQ_STATUS_OFS = 16'h2f60;  // read only
    localparam logic [15:0] IRQ_CLEAR_OFS  = 16'h2f61;  // write only, one clears
    localparam logic [15:0] IRQ_ENABLE_OFS = 16'h2f62;
    localparam logic [15:0] MISC_CTRL_OFS  = 16'h2f63;

    // ------------
    // fields and reset values
    // ------------
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         IRQ_PCHG_BIT   = 0;  // port 0 pin change seen
    localparam int         IRQ_PRST_BIT   = 1;  // filtered port reset asserted
    localparam int         CTRL_PRST_BIT  = 0;  // port 2 pin 2 acts as reset input
    localparam int         RST_PIN_IDX    = 18; // port 2 pin 2 in the flat pin vector
    localparam int         ANA_HIGH_PORT  = 2;  // port steered by the high analog select

    // ------------
    // timing
    // ------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int DB_TIME_NS      = 5000;
    localparam int DB_RST_TIME_NS  = 7000;
    localparam int NC_TIME_NS      = 5000;
    localparam int DB_CYCLES       = (DB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DB_RST_CYCLES   = (DB_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int NC_CYCLES       = (NC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W           = 11;

endpackage

// ### hw/gpio_ports_pin_change.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps

// How it works
// RQ1: four eight-pin ports with five control registers
// RQ2: data registers at 80H, 88H, 90H, 98H
// RQ3: output pins drive written data; inputs read pins
// RQ4: direction 0 input, 1 output; at 89H..A1H
// RQ5: pull-up bit one enables the pin pull-up
// RQ6: pull-up selects at 2F00H through 2F03H
// RQ7: open-drain selects at 2F0CH..2F0FH; set means open-drain
// RQ8: debounce enables at 2F18H through 2F1BH
// RQ9: debounce rejects under 5us; reset pin 7us
// RQ10: pin-change interrupt on port 0, enable at AEH
// RQ11: enabled port 0 pin toggling raises request
// RQ12: enable bit includes pin; cleared at reset
// RQ13: analog select forces digital input to one
// RQ14: low analog select bits map to port 0
// RQ15: port reset input filtered against 5us glitches
// RQ16: reset clears all direction bits, pins input
// RQ17: synchronise port 0, compare samples, one-cycle request
// RQ18: read outputs from latch, inputs from filtered pin
module gpio_ports_pin_change #(
    parameter int DB_COUNT     = gpio_pkg::DB_CYCLES,     // short debounce length, cycles
    parameter int DB_RST_COUNT = gpio_pkg::DB_RST_CYCLES, // reset-pin debounce length, cycles
    parameter int NC_COUNT     = gpio_pkg::NC_CYCLES      // port reset canceller length, cycles
) (
    input  wire logic        clk_in,             // system clock, 200 MHz
    input  wire logic        rst_n_in,           // asynchronous system reset, low
    input  wire logic [15:0] addr_in,            // register address
    input  wire logic [7:0]  wdata_in,           // register write data
    input  wire logic        wr_in,              // write strobe
    input  wire logic        rd_in,              // read strobe
    output logic      [7:0]  rdata_out,          // read data, cycle after the strobe
    input  wire logic [31:0] pin_in,             // pad levels, port n at bits 8n+7..8n
    output logic      [31:0] pin_out,            // pad output levels
    output logic      [31:0] pin_oe_out,         // pad output enables, high drives
    output logic      [31:0] pullup_out,         // pad pull-up enables
    output logic      [31:0] input_cut_out,      // pad input buffer cut for analog use
    output logic             pin_change_req_out, // one-cycle request to the interrupt controller
    output logic             port_reset_n_out,   // filtered port reset, low asserts
    output logic             irq_out             // level interrupt
);

    localparam int NP = gpio_pkg::NUM_PORTS;
    localparam int NB = gpio_pkg::NUM_PORTS * gpio_pkg::PINS;

    // ------------
    // register file state
    // ------------
    logic [NP-1:0][7:0] data_r, data_nxt;  // [RQ1]
    logic [NP-1:0][7:0] dir_r, dir_nxt;
    logic [NP-1:0][7:0] pu_r, pu_nxt;
    logic [NP-1:0][7:0] od_r, od_nxt;
    logic [NP-1:0][7:0] db_r, db_nxt;
    logic [7:0]         pci_r, pci_nxt;
    logic [7:0]         ana_low_r, ana_low_nxt;
    logic [7:0]         ana_high_r, ana_high_nxt;
    logic [7:0]         irq_stat_r, irq_stat_nxt;
    logic [7:0]         irq_en_r, irq_en_nxt;
    logic [7:0]         ctrl_r, ctrl_nxt;
    logic [7:0]         rdata_r, rdata_nxt;

    // ------------
    // pin path state
    // ------------
    logic [NB-1:0] sync1_r;
    logic [NB-1:0] sync2_r;
    logic [NB-1:0] filt_r;
    logic [NB-1:0] in_val;
    logic [NB-1:0] ana_mask;
    logic [7:0]    p0_prev_r, p0_prev_nxt;
    logic          pchg_r, pchg_nxt;
    logic          prst_n_r, prst_n_nxt;
    logic          prst_n_d_r;
    logic [gpio_pkg::CNT_W-1:0] nc_cnt_r, nc_cnt_nxt;
    logic          rst_pin_mode;
    logic [7:0]    pchg_diff;
    logic          prst_event;

    assign rst_pin_mode = ctrl_r[gpio_pkg::CTRL_PRST_BIT];

    // ------------
    // input synchroniser
    // ------------
    // first stage feeds only the second stage, to keep metastability contained
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // ------------
    // per-pin debounce filter
    // ------------
    // a level is accepted only after it held steady for the full window;
    // any shorter excursion restarts the count and is lost
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_pin
            logic [gpio_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
            logic                       filt_nxt;
            logic [gpio_pkg::CNT_W-1:0] limit;

            // reset pin gets the longer window when it is used as reset
            assign limit = (gi == gpio_pkg::RST_PIN_IDX && rst_pin_mode) ?
                           gpio_pkg::CNT_W'(DB_RST_COUNT - 1) :
                           gpio_pkg::CNT_W'(DB_COUNT - 1);  // [RQ9]

            always_comb begin
                cnt_nxt  = '0;
                filt_nxt = filt_r[gi];
                if (!db_r[gi / 8][gi % 8]) begin
                    filt_nxt = sync2_r[gi];                       // [RQ8]
                end else if (sync2_r[gi] != filt_r[gi]) begin
                    if (cnt_r >= limit) begin
                        filt_nxt = sync2_r[gi];                   // [RQ9]
                    end else begin
                        cnt_nxt = cnt_r + gpio_pkg::CNT_W'(1);
                    end
                end
            end

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    cnt_r      <= '0;
                    filt_r[gi] <= 1'b0;
                end else begin
                    cnt_r      <= cnt_nxt;
                    filt_r[gi] <= filt_nxt;
                end
            end

            // analog use cuts the input path; the digital value reads as one
            assign in_val[gi] = ana_mask[gi] ? 1'b1 : filt_r[gi];     // [RQ13]

            // open-drain drives only low; a high leaves the pad released
            assign pin_out[gi]    = data_r[gi / 8][gi % 8];          // [RQ3]
            assign pin_oe_out[gi] = dir_r[gi / 8][gi % 8] &
                                    (~od_r[gi / 8][gi % 8] |
                                     ~data_r[gi / 8][gi % 8]);       // [RQ4] [RQ7]
            assign pullup_out[gi] = pu_r[gi / 8][gi % 8];            // [RQ5]
        end
    endgenerate

    // low select steers port 0, high select steers the analog-capable port
    always_comb begin
        ana_mask = '0;
        ana_mask[7:0] = ana_low_r;                                   // [RQ14]
        ana_mask[gpio_pkg::ANA_HIGH_PORT*8 +: 8] = ana_high_r;
    end
    assign input_cut_out = ana_mask;                                 // [RQ13]

    // ------------
    // port 0 pin change detection
    // ------------
    // the previous sample follows every cycle, so each toggle gives one pulse
    always_comb begin
        pchg_diff   = (in_val[7:0] ^ p0_prev_r) & pci_r;             // [RQ11] [RQ12]
        pchg_nxt    = |pchg_diff;                                    // [RQ17]
        p0_prev_nxt = in_val[7:0];                                   // [RQ17]
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            p0_prev_r <= '0;
            pchg_r    <= 1'b0;
        end else begin
            p0_prev_r <= p0_prev_nxt;
            pchg_r    <= pchg_nxt;
        end
    end

    assign pin_change_req_out = pchg_r;                              // [RQ10]

    // ------------
    // port reset noise canceller
    // ------------
    // the raw synchronised pin must stay at the new level for the whole
    // window before the filtered reset follows, in either direction
    always_comb begin
        nc_cnt_nxt = '0;
        prst_n_nxt = prst_n_r;
        if (!rst_pin_mode) begin
            prst_n_nxt = 1'b1;
        end else if (sync2_r[gpio_pkg::RST_PIN_IDX] != prst_n_r) begin
            if (nc_cnt_r >= gpio_pkg::CNT_W'(NC_COUNT - 1)) begin
                prst_n_nxt = sync2_r[gpio_pkg::RST_PIN_IDX];         // [RQ15]
            end else begin
                nc_cnt_nxt = nc_cnt_r + gpio_pkg::CNT_W'(1);         // [RQ15]
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nc_cnt_r   <= '0;
            prst_n_r   <= 1'b1;
            prst_n_d_r <= 1'b1;
        end else begin
            nc_cnt_r   <= nc_cnt_nxt;
            prst_n_r   <= prst_n_nxt;
            prst_n_d_r <= prst_n_r;
        end
    end

    assign port_reset_n_out = prst_n_r;
    assign prst_event       = prst_n_d_r & ~prst_n_r;

    // ------------
    // register writes and interrupt status
    // ------------
    // status set wins over a clear arriving in the same cycle
    always_comb begin
        data_nxt     = data_r;
        dir_nxt      = dir_r;
        pu_nxt       = pu_r;
        od_nxt       = od_r;
        db_nxt       = db_r;
        pci_nxt      = pci_r;
        ana_low_nxt  = ana_low_r;
        ana_high_nxt = ana_high_r;
        irq_en_nxt   = irq_en_r;
        ctrl_nxt     = ctrl_r;
        irq_stat_nxt = irq_stat_r;
        if (wr_in) begin
            for (int p = 0; p < NP; p++) begin
                if (addr_in == gpio_pkg::DATA_OFS[p]) data_nxt[p] = wdata_in; // [RQ2] [RQ3]
                if (addr_in == gpio_pkg::DIR_OFS[p])  dir_nxt[p]  = wdata_in; // [RQ4]
                if (addr_in == gpio_pkg::PU_OFS[p])   pu_nxt[p]   = wdata_in; // [RQ6]
                if (addr_in == gpio_pkg::OD_OFS[p])   od_nxt[p]   = wdata_in; // [RQ7]
                if (addr_in == gpio_pkg::DB_OFS[p])   db_nxt[p]   = wdata_in; // [RQ8]
            end
            if (addr_in == gpio_pkg::PCI_OFS)        pci_nxt      = wdata_in; // [RQ10]
            if (addr_in == gpio_pkg::ANA_LOW_OFS)    ana_low_nxt  = wdata_in; // [RQ14]
            if (addr_in == gpio_pkg::ANA_HIGH_OFS)   ana_high_nxt = wdata_in;
            if (addr_in == gpio_pkg::IRQ_ENABLE_OFS) irq_en_nxt   = wdata_in;
            if (addr_in == gpio_pkg::MISC_CTRL_OFS)  ctrl_nxt     = wdata_in;
            if (addr_in == gpio_pkg::IRQ_CLEAR_OFS)  irq_stat_nxt = irq_stat_r & ~wdata_in;
        end
        if (pchg_nxt) irq_stat_nxt[gpio_pkg::IRQ_PCHG_BIT] = 1'b1;
        if (prst_event) irq_stat_nxt[gpio_pkg::IRQ_PRST_BIT] = 1'b1;
        // only two status bits exist; the rest read as zero
        irq_stat_nxt[7:2] = '0;
    end

    // ------------
    // register read path
    // ------------
    // data reads mix latch and pin per bit, chosen by direction
    always_comb begin
        rdata_nxt = '0;
        if (rd_in) begin
            for (int p = 0; p < NP; p++) begin
                if (addr_in == gpio_pkg::DATA_OFS[p]) begin
                    rdata_nxt = (dir_r[p] & data_r[p]) |
                                (~dir_r[p] & in_val[p*8 +: 8]);             // [RQ18] [RQ3]
                end
                if (addr_in == gpio_pkg::DIR_OFS[p]) rdata_nxt = dir_r[p];
                if (addr_in == gpio_pkg::PU_OFS[p])  rdata_nxt = pu_r[p];
                if (addr_in == gpio_pkg::OD_OFS[p])  rdata_nxt = od_r[p];
                if (addr_in == gpio_pkg::DB_OFS[p])  rdata_nxt = db_r[p];
            end
            if (addr_in == gpio_pkg::PCI_OFS)        rdata_nxt = pci_r;
            if (addr_in == gpio_pkg::ANA_LOW_OFS)    rdata_nxt = ana_low_r;
            if (addr_in == gpio_pkg::ANA_HIGH_OFS)   rdata_nxt = ana_high_r;
            if (addr_in == gpio_pkg::IRQ_STATUS_OFS) rdata_nxt = irq_stat_r;
            if (addr_in == gpio_pkg::IRQ_ENABLE_OFS) rdata_nxt = irq_en_r;
            if (addr_in == gpio_pkg::MISC_CTRL_OFS)  rdata_nxt = ctrl_r;
        end
    end

    // ------------
    // register bank flops
    // ------------
    // every control register clears, so all pins start as plain inputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int p = 0; p < NP; p++) begin
                data_r[p] <= gpio_pkg::REG_RESET;
                dir_r[p]  <= gpio_pkg::REG_RESET;  // [RQ16]
                pu_r[p]   <= gpio_pkg::REG_RESET;
                od_r[p]   <= gpio_pkg::REG_RESET;
                db_r[p]   <= gpio_pkg::REG_RESET;
            end
            pci_r      <= gpio_pkg::REG_RESET;     // [RQ12]
            ana_low_r  <= gpio_pkg::REG_RESET;
            ana_high_r <= gpio_pkg::REG_RESET;
            irq_stat_r <= gpio_pkg::REG_RESET;
            irq_en_r   <= gpio_pkg::REG_RESET;
            ctrl_r     <= gpio_pkg::REG_RESET;
            rdata_r    <= gpio_pkg::REG_RESET;
        end else begin
            data_r     <= data_nxt;
            dir_r      <= dir_nxt;
            pu_r       <= pu_nxt;
            od_r       <= od_nxt;
            db_r       <= db_nxt;
            pci_r      <= pci_nxt;
            ana_low_r  <= ana_low_nxt;
            ana_high_r <= ana_high_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r   <= irq_en_nxt;
            ctrl_r     <= ctrl_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign irq_out   = |(irq_stat_r & irq_en_r);

endmodule // gpio_ports_pin_change

// ### sim/gpio_checker_sva.sv
`timescale 1ns/100ps
// ------------
// port-level checks of the gpio block
// ------------
module gpio_checker_sva #(
    parameter int NC_COUNT = 4 // port reset filter length, cycles
) (
    input wire logic        clk_in,             // system clock
    input wire logic        rst_n_in,           // reset, low
    input wire logic [15:0] addr_in,            // register address
    input wire logic [7:0]  wdata_in,           // write data
    input wire logic        wr_in,              // write strobe
    input wire logic        rd_in,              // read strobe
    input wire logic [7:0]  rdata_out,          // read data
    input wire logic [31:0] pin_in,             // pad levels
    input wire logic [31:0] pin_out,            // pad output levels
    input wire logic [31:0] pin_oe_out,         // pad output enables
    input wire logic [31:0] pullup_out,         // pull-up enables
    input wire logic [31:0] input_cut_out,      // analog input cuts
    input wire logic        pin_change_req_out, // change request
    input wire logic        port_reset_n_out,   // filtered port reset
    input wire logic        irq_out             // level interrupt
);
    logic        pci_seen_r;
    logic        pci_seen_nxt;
    logic [10:0] low_cnt_r;
    logic [10:0] low_cnt_nxt;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // a request before any change enable was written is bogus; count raw low time of the reset pin
    always_comb begin
        pci_seen_nxt = pci_seen_r | (wr_in && addr_in == 16'h00ae && wdata_in != 8'h00);
        low_cnt_nxt  = pin_in[18] ? 11'h000 : (low_cnt_r == 11'h7ff) ? low_cnt_r : low_cnt_r + 11'h001;
    end

    // helper registers; the count saturates so a long low never wraps
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pci_seen_r <= 1'b0;
            low_cnt_r  <= 11'h000;
        end else begin
            pci_seen_r <= pci_seen_nxt;
            low_cnt_r  <= low_cnt_nxt;
        end
    end

    a_req_single_pulse: assert property (pin_change_req_out |=> !pin_change_req_out)
        else $error("change request longer than one cycle");
    a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data present without a read");
    a_data_drives_pin: assert property (wr_in && addr_in == 16'h0088 |=> pin_out[15:8] == $past(wdata_in))
        else $error("port 1 latch not on pins");
    a_input_no_drive: assert property (wr_in && addr_in == 16'h0091 |=> (pin_oe_out[15:8] & ~$past(wdata_in)) == 8'h00)
        else $error("input pin driven");
    a_pullup_follows: assert property (wr_in && addr_in == 16'h2f03 |=> pullup_out[31:24] == $past(wdata_in))
        else $error("port 3 pull-ups wrong");
    a_analog_cut_low: assert property (wr_in && addr_in == 16'h2f50 |=> input_cut_out[7:0] == $past(wdata_in))
        else $error("port 0 input cut wrong");
    a_reset_all_inputs: assert property ($rose(rst_n_in) |-> pin_oe_out == 32'h0000_0000 && !pin_change_req_out)
        else $error("pins not inputs after reset");
    a_req_needs_enable: assert property (pin_change_req_out |-> pci_seen_r)
        else $error("change request with no pin enabled");
    a_reset_filtered: assert property ($fell(port_reset_n_out) |-> low_cnt_r >= 11'(NC_COUNT))
        else $error("port reset taken from a short pulse");
endmodule // gpio_checker_sva

bind gpio_ports_pin_change gpio_checker_sva #(.NC_COUNT(NC_COUNT)) u_gpio_checker_sva (.*);

// ### sim/pad_model.sv
`timescale 1ns/100ps
// ------------
// board side of the pads
// ------------
module pad_model (
    input  wire logic        clk_in,     // system clock
    input  wire logic        rst_n_in,   // reset, low
    input  wire logic [31:0] drv_lvl_in, // level the block drives
    input  wire logic [31:0] drv_en_in,  // block drives the pad
    input  wire logic [31:0] pull_en_in, // internal pull-up on
    input  wire logic [31:0] ext_en_in,  // board source connected
    input  wire logic [31:0] ext_val_in, // board source level
    output logic      [31:0] pad_out     // resolved pad level
);
    logic [31:0] float_r;

    // a floating pad wanders every cycle so no reader can lean on a stale value
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            float_r <= 32'h0000_0000;
        end else begin
            float_r <= ~float_r;
        end
    end

    // block driver wins, board source is weak, then pull-up, else float
    assign pad_out = (drv_en_in & drv_lvl_in) | (~drv_en_in & ext_en_in & ext_val_in)
                   | (~drv_en_in & ~ext_en_in & (pull_en_in | float_r));
endmodule // pad_model

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        clk_in, rst_n_in, wr_in, rd_in, pin_change_req_out, port_reset_n_out, irq_out;
    logic [15:0] addr_in;
    logic [7:0]  wdata_in, rdata_out;
    logic [31:0] pin_in, pin_out, pin_oe_out, pullup_out, input_cut_out, ext_en, ext_val;
    int          err_total = 0;
    int          total_checks = 0;
    bit          seen;

    // short filter counts keep the run brief
    gpio_ports_pin_change #(.DB_COUNT(4), .DB_RST_COUNT(6), .NC_COUNT(4)) u_gpio_ports_pin_change (.*);
    pad_model u_pad_model (.clk_in, .rst_n_in, .drv_lvl_in(pin_out), .drv_en_in(pin_oe_out),
        .pull_en_in(pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pin_in));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // ------------
    // bus and compare helpers
    // ------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1; // callers look at outputs only after the write has landed
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(what, 32'(exp), 32'(rdata_out));
    endtask
    task automatic wait_req(input int lim);
        seen = 0;
        repeat (lim) begin
            @(posedge clk_in);
            #1;
            if (pin_change_req_out === 1'b1) seen = 1;
        end
    endtask
    task automatic pins(input int lo, input logic [7:0] v, input int hold);
        @(posedge clk_in);
        ext_val[lo+:8] <= v;
        repeat (hold) @(posedge clk_in);
    endtask

    // ------------
    // scenarios
    // ------------
    task automatic t_reset_vals();
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            rd(gpio_pkg::DIR_OFS[p], 8'h00, "direction");
            rd(gpio_pkg::PU_OFS[p], 8'h00, "pull-up");
            rd(gpio_pkg::OD_OFS[p], 8'h00, "open-drain");
            rd(gpio_pkg::DB_OFS[p], 8'h00, "debounce");
        end
        rd(gpio_pkg::PCI_OFS, 8'h00, "change enable");
        rd(gpio_pkg::ANA_LOW_OFS, 8'h00, "analog low");
        wr(16'h0081, 8'hff);
        rd(16'h0081, 8'h00, "unmapped");
        chk("oe at reset", 32'h0000_0000, pin_oe_out);
        $display("test reset_vals done");
    endtask
    task automatic t_reg_rw();
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            wr(gpio_pkg::PU_OFS[p], 8'(8'h3c + p));
            wr(gpio_pkg::OD_OFS[p], 8'(8'hc3 - p));
            wr(gpio_pkg::DB_OFS[p], 8'(8'h5a ^ p));
        end
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            rd(gpio_pkg::PU_OFS[p], 8'(8'h3c + p), "pull-up rw");
            rd(gpio_pkg::OD_OFS[p], 8'(8'hc3 - p), "open-drain rw");
            rd(gpio_pkg::DB_OFS[p], 8'(8'h5a ^ p), "debounce rw");
            chk("pull-up pins", 32'(8'(8'h3c + p)), 32'(pullup_out[8*p+:8]));
            wr(gpio_pkg::PU_OFS[p], 8'h00);
            wr(gpio_pkg::OD_OFS[p], 8'h00);
            wr(gpio_pkg::DB_OFS[p], 8'h00);
        end
        $display("test reg_rw done");
    endtask
    task automatic t_drive();
        wr(gpio_pkg::DIR_OFS[1], 8'hff);
        wr(gpio_pkg::DATA_OFS[1], 8'ha5);
        chk("oe push-pull", 32'h0000_ff00, pin_oe_out);
        chk("pin level", 32'h0000_a500, pin_out & 32'h0000_ff00);
        rd(gpio_pkg::DATA_OFS[1], 8'ha5, "latch read");
        wr(gpio_pkg::OD_OFS[1], 8'hff);
        chk("oe open-drain", 32'h0000_5a00, pin_oe_out);
        wr(gpio_pkg::OD_OFS[1], 8'h00);
        wr(gpio_pkg::DIR_OFS[1], 8'h00);
        $display("test drive done");
    endtask
    task automatic t_input();
        pins(24, 8'h3c, 6);
        rd(gpio_pkg::DATA_OFS[3], 8'h3c, "pin read");
        wr(gpio_pkg::DATA_OFS[3], 8'ha0);
        wr(gpio_pkg::DIR_OFS[3], 8'h0f);
        rd(gpio_pkg::DATA_OFS[3], 8'h30, "mixed read");
        wr(gpio_pkg::DIR_OFS[3], 8'h00);
        $display("test input done");
    endtask
    task automatic t_debounce();
        wr(gpio_pkg::DB_OFS[2], 8'hff);
        pins(16, 8'h00, 2);
        pins(16, 8'hff, 12);
        rd(gpio_pkg::DATA_OFS[2], 8'hff, "short pulse");
        pins(16, 8'h00, 12);
        rd(gpio_pkg::DATA_OFS[2], 8'h00, "long level");
        pins(16, 8'hff, 12);
        wr(gpio_pkg::DB_OFS[2], 8'h00);
        $display("test debounce done");
    endtask
    task automatic t_pin_change();
        wr(gpio_pkg::IRQ_ENABLE_OFS, 8'h01);
        wr(gpio_pkg::PCI_OFS, 8'h81);
        pins(0, 8'h02, 0);
        wait_req(10);
        chk("masked pin", 32'h0, 32'(seen));
        for (int i = 0; i < 3; i++) begin
            pins(0, (i == 1) ? 8'h83 : (i == 0) ? 8'h03 : 8'h82, 0);
            wait_req(10);
            chk("pin change", 32'h1, 32'(seen));
        end
        chk("irq level", 32'h1, 32'(irq_out));
        rd(gpio_pkg::IRQ_STATUS_OFS, 8'h01, "status");
        wr(gpio_pkg::IRQ_CLEAR_OFS, 8'h01);
        chk("irq cleared", 32'h0, 32'(irq_out));
        wr(gpio_pkg::IRQ_ENABLE_OFS, 8'h00);
        pins(0, 8'h00, 10);
        chk("irq masked", 32'h0, 32'(irq_out));
        rd(gpio_pkg::IRQ_STATUS_OFS, 8'h01, "status masked");
        wr(gpio_pkg::PCI_OFS, 8'h00);
        wr(gpio_pkg::IRQ_CLEAR_OFS, 8'h01);
        $display("test pin_change done");
    endtask
    task automatic t_analog();
        wr(gpio_pkg::ANA_LOW_OFS, 8'h0f);
        chk("cut low", 32'h0000_000f, input_cut_out);
        rd(gpio_pkg::DATA_OFS[0], 8'h0f, "analog reads one");
        wr(gpio_pkg::ANA_LOW_OFS, 8'h00);
        wr(gpio_pkg::ANA_HIGH_OFS, 8'hf0);
        chk("cut high", 32'h00f0_0000, input_cut_out);
        wr(gpio_pkg::ANA_HIGH_OFS, 8'h00);
        $display("test analog done");
    endtask
    task automatic t_port_reset();
        wr(gpio_pkg::MISC_CTRL_OFS, 8'h01);
        wr(gpio_pkg::IRQ_ENABLE_OFS, 8'h02);
        pins(16, 8'hfb, 2);
        pins(16, 8'hff, 14);
        chk("glitch ignored", 32'h1, 32'(port_reset_n_out));
        pins(16, 8'hfb, 16);
        chk("reset asserted", 32'h0, 32'(port_reset_n_out));
        chk("reset irq", 32'h1, 32'(irq_out));
        pins(16, 8'hff, 16);
        chk("reset released", 32'h1, 32'(port_reset_n_out));
        wr(gpio_pkg::IRQ_CLEAR_OFS, 8'h02);
        $display("test port_reset done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence; reset held six cycles
    initial begin
        rst_n_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 16'h0000;
        wdata_in = 8'h00;
        ext_en = 32'hffff_ffff;
        ext_val = 32'h00ff_0000;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset_vals();
        t_reg_rw();
        t_drive();
        t_input();
        t_debounce();
        t_pin_change();
        t_analog();
        t_port_reset();
        complete_run();
    end

    // the tests need a few hundred cycles; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        complete_run();
    end
endmodule // tb_top
